/* dv/qdi_assertions.sv */
`timescale 1ns/100ps
// ====================
// Bus checks.
module qdi_assertions
(
    // Clock, reset and bus
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic scl,
    input wire logic sda,
    input wire logic s_sda_oe
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    property p_start; $fell(sda) && scl |-> !s_sda_oe; endproperty
    a_start: assert property (p_start) else $error("a_start");
    property p_stop; $rose(sda) && scl |=> !s_sda_oe [*8]; endproperty
    a_stop: assert property (p_stop) else $error("a_stop");
    property p_on; $rose(s_sda_oe) |-> !scl; endproperty
    a_on: assert property (p_on) else $error("a_on");
    property p_hold; s_sda_oe && scl |=> s_sda_oe || !scl; endproperty
    a_hold: assert property (p_hold) else $error("a_hold");
    property p_off; $fell(s_sda_oe) |-> !scl; endproperty
    a_off: assert property (p_off) else $error("a_off");
    property p_rel; s_sda_oe && $fell(scl) |-> ##[2:5] !s_sda_oe; endproperty
    a_rel: assert property (p_rel) else $error("a_rel");
    property p_len; $rose(s_sda_oe) |-> s_sda_oe [*5]; endproperty
    a_len: assert property (p_len) else $error("a_len");
    property p_scl; $rose(scl) |-> scl [*4]; endproperty
    a_scl: assert property (p_scl) else $error("a_scl");
endmodule // qdi_assertions

/* dv/tb_quad_dac_i2c_write_slave.sv */
`timescale 1ns/100ps
// ====================
// Host and device joined on one bus, driven over APB.
module tb_quad_dac_i2c_write_slave;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, hs, cmt;
    int          commits = 0;
    always @(posedge clk) if (cmt === 1'b1) commits++;
    logic [7:0]  pa = 8'h00, ctl;
    logic [31:0] pwd = 32'h0, prd;
    logic [67:0] word;
    int          num_errors = 0, checked = 0, n, m;
    always #5 clk = ~clk;
    qdi_bus_if u_qdi_bus_if ();
    qdi_host u_qdi_host (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(), .BUS(u_qdi_bus_if));
    qdi_dev u_qdi_dev (.I_CLK(clk), .I_RESET(rst), .BUS(u_qdi_bus_if), .I_STRAP_SEL_HI(1'b0), .I_STRAP_SEL_LO(1'b1),
        .I_EXT_ADDR_HI(1'b1), .I_EXT_ADDR_LO(1'b0), .O_DAC_WORD(word), .O_COMMIT(cmt), .O_HS_MODE(hs),
        .O_UPDATE_CONTROL(ctl));
    qdi_assertions u_qdi_assertions (.I_CLK(clk), .I_RESET(rst), .scl(u_qdi_bus_if.scl), .sda(u_qdi_bus_if.sda),
        .s_sda_oe(u_qdi_bus_if.s_sda_oe));
    task conclude(input int bad);
        num_errors += bad;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        checked++;
        num_errors += int'(g !== e);
        if (g !== e)
            $display("Error %s exp %h got %h", nm, e, g);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk) pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rdy !== 1'b1 && n < 50);
        {psel, pen} <= 2'b00;
        if (rdy !== 1'b1) conclude(1);
    endtask
    // The default divider is slow, so the busy poll allows a long byte.
    task cmd(input logic [1:0] op, input logic [7:0] b);
        apb(1'b1, 8'h00, {16'h0000, b, 6'h00, op});
        m = 0;
        do apb(1'b0, 8'h04, 32'h0); while (prd[0] !== 1'b0 && ++m < 2000);
        if (m == 2000) conclude(1);
    endtask
    task t_update;
        cmd(2'h1, 8'h00);
        cmd(2'h2, 8'h9a);
        cmd(2'h2, 8'h90);
        cmd(2'h2, 8'hab);
        cmd(2'h2, 8'hcd);
        repeat (8) @(posedge clk);
        chk("word a", 17'h0abcd, word[16:0]);
        chk("control", 17'h00090, {9'h000, ctl});
        cmd(2'h2, 8'h81);
        cmd(2'h2, 8'h02);
        repeat (8) @(posedge clk);
        chk("word b", 17'h08102, word[16:0]);
        chk("commits", 17'h00002, 17'(commits));
        cmd(2'h3, 8'h00);
        $display("t_update done");
    endtask
    task t_refuse;
        logic [9:0] tab [6] = '{10'h098, 10'h091, 10'h000, 10'h0f0, 10'h208, 10'h390};
        for (int i = 0; i < 6; i++)
        begin
            cmd(2'h1, 8'h00);
            cmd(2'h2, tab[i][7:0]);
            chk("addr", {15'h0, tab[i][9:8]}, {15'h0, hs, prd[1]});
        end
        cmd(2'h3, 8'h00);
        repeat (8) @(posedge clk);
        chk("hs off", 17'h0, {16'h0, hs});
        $display("t_refuse done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_update;
        t_refuse;
        conclude(0);
    end
endmodule // tb_quad_dac_i2c_write_slave

/* hw/qdi_bus_if.sv */
`timescale 1ns/100ps
interface qdi_bus_if;
    logic scl_o;
    logic scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // Open drain with pull-up: any enabled low driver wins.
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

    modport dev  (input scl, input sda, output s_sda_o, output s_sda_oe);
    modport host (input scl, input sda, output scl_o, output scl_oe, output m_sda_o, output m_sda_oe);
endinterface

/* hw/qdi_consts.svh */
`ifndef QDI_CONSTS_SVH
`define QDI_CONSTS_SVH

// ==========================================================
// Address bytes
`define QDI_ADDR_PREFIX   5'h13
`define QDI_BCAST_WRITE   8'h90
`define QDI_MCODE_PREFIX  5'h01

// ==========================================================
// Control byte fields
`define QDI_CTL_EXT       7:6
`define QDI_CTL_LOAD      5:4
`define QDI_CTL_SEL       2:1
`define QDI_CTL_SEL_HI    2
`define QDI_CTL_PD        0
`define QDI_CTL_RESET     8'h00

// ==========================================================
// Channels and words
`define QDI_NCHAN         4
`define QDI_WORD_W        17
`define QDI_STRAP_SETTLE  2'h3

// ==========================================================
// Controller registers
`define QDI_REG_CMD       8'h00
`define QDI_REG_STATUS    8'h04
`define QDI_REG_DIV       8'h08
`define QDI_OP_START      2'h1
`define QDI_OP_WRITE      2'h2
`define QDI_OP_STOP       2'h3

// ==========================================================
// Timing
`define QDI_CLK_NS        10
`define QDI_FS_HALF_NS    1250
`define QDI_DIV_RESET     (`QDI_FS_HALF_NS / `QDI_CLK_NS)

`endif

/* hw/qdi_dev.sv */
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "qdi_consts.svh"

// Behaviour
// [RULE_01] Slave at standard, fast and high-speed rates.
// [RULE_02] Seven-bit addresses only, no general call.
// [RULE_03] SDA falling with SCL high starts.
// [RULE_04] Master keeps SDA stable while SCL high.
// [RULE_05] Matching address acknowledged through ninth pulse.
// [RULE_06] Receiver acknowledges every byte, units repeat.
// [RULE_07] SDA rising with SCL high stops.
// [RULE_08] Master code unacknowledged, enters high speed.
// [RULE_09] Repeated start keeps high speed, stop leaves.
// [RULE_10] Address, control, MSB, LSB, each acknowledged.
// [RULE_11] Commit at falling edge ending LSB acknowledge.
// [RULE_12] Stored control byte governs following pairs.
// [RULE_13] Back-to-back updates every eighteen SCL cycles.
// [RULE_14] Address is 10011, two straps, direction.
// [RULE_15] Strap levels latched once after power-up.
// [RULE_16] Broadcast address 10010000 always acknowledged.
// [RULE_17] Broadcast read direction not acknowledged.
// [RULE_18] Control: ext, load, spare, select, powerdown.
// [RULE_19] Extended bits must match second strap pair.
// [RULE_20] Load modes hold, one, sync, broadcast.
// [RULE_21] Broadcast select-high picks new or holding.
// [RULE_22] Unmatched address: release SDA until start.
module qdi_dev
(
    // Clock and reset
    input  wire logic                           I_CLK,
    input  wire logic                           I_RESET,
    // Two-wire bus
    qdi_bus_if.dev                              BUS,
    // Address straps
    input  wire logic                           I_STRAP_SEL_HI,
    input  wire logic                           I_STRAP_SEL_LO,
    input  wire logic                           I_EXT_ADDR_HI,
    input  wire logic                           I_EXT_ADDR_LO,
    // Channel side
    output logic [`QDI_NCHAN*`QDI_WORD_W-1:0]   O_DAC_WORD,
    output logic                                O_COMMIT,
    output logic                                O_HS_MODE,
    output logic [7:0]                          O_UPDATE_CONTROL
);

    // ==========================================================
    // Declarations
    localparam int W = `QDI_WORD_W;
    localparam int N = `QDI_NCHAN;

    logic                  scl_s1_q, scl_s2_q, scl_s3_q;
    logic                  sda_s1_q, sda_s2_q, sda_s3_q;
    logic [3:0]            strap_s1_q, strap_s2_q, strap_q, strap_d;
    logic [1:0]            settle_q, settle_d;
    logic                  strap_done_q, strap_done_d;
    qdi_pkg::qdi_dstate_t  state_q, state_d;
    qdi_pkg::qdi_phase_t   phase_q, phase_d;
    logic [3:0]            bit_q, bit_d;
    logic [7:0]            shift_q, shift_d;
    logic                  oe_q, oe_d;
    logic                  rd_q, rd_d;
    logic                  hs_q, hs_d;
    logic                  commit_q, commit_d;
    logic [7:0]            ctl_q, ctl_d;
    logic [7:0]            msb_q, msb_d;
    logic [7:0]            lsb_q, lsb_d;
    logic [W-1:0]          hold_q [N];
    logic [W-1:0]          hold_d [N];
    logic [W-1:0]          act_q  [N];
    logic [W-1:0]          act_d  [N];
    logic                  scl_rise, scl_fall, start_seen, stop_seen;
    logic [W-1:0]          new_word;
    logic [1:0]            sel;
    qdi_pkg::qdi_load_t    mode;

    function automatic logic own_addr(input logic [7:0] b, input logic [1:0] s);
        own_addr = (b[7:3] == `QDI_ADDR_PREFIX) && (b[2:1] == s); // [RULE_14]
    endfunction

    // ==========================================================
    // Synchronisers and bus conditions
    // The third stage only exists to find edges; stage one feeds stage two alone.
    always_ff @(posedge I_CLK)
    begin
        scl_s1_q   <= BUS.scl;
        scl_s2_q   <= scl_s1_q;
        scl_s3_q   <= scl_s2_q;
        sda_s1_q   <= BUS.sda;
        sda_s2_q   <= sda_s1_q;
        sda_s3_q   <= sda_s2_q;
        strap_s1_q <= {I_EXT_ADDR_HI, I_EXT_ADDR_LO, I_STRAP_SEL_HI, I_STRAP_SEL_LO};
        strap_s2_q <= strap_s1_q;
    end

    assign scl_rise   = scl_s2_q && !scl_s3_q;
    assign scl_fall   = !scl_s2_q && scl_s3_q;
    assign start_seen = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q; // [RULE_03]
    assign stop_seen  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q; // [RULE_07]

    assign new_word = {ctl_q[`QDI_CTL_PD], msb_q, lsb_q};
    assign sel      = ctl_q[`QDI_CTL_SEL]; // [RULE_18]
    assign mode     = qdi_pkg::qdi_load_t'(ctl_q[`QDI_CTL_LOAD]);

    // ==========================================================
    // Next state
    always_comb
    begin
        strap_d      = strap_q;
        settle_d     = settle_q;
        strap_done_d = strap_done_q;
        state_d      = state_q;
        phase_d      = phase_q;
        bit_d        = bit_q;
        shift_d      = shift_q;
        oe_d         = oe_q;
        rd_d         = rd_q;
        hs_d         = hs_q;
        commit_d     = 1'b0;
        ctl_d        = ctl_q;
        msb_d        = msb_q;
        lsb_d        = lsb_q;
        hold_d       = hold_q;
        act_d        = act_q;

        // Straps are caught once after the synchroniser has filled; later pin changes are ignored.
        if (!strap_done_q)
        begin
            settle_d = settle_q + 2'h1;
            if (settle_q == `QDI_STRAP_SETTLE)
            begin
                strap_d      = strap_s2_q; // [RULE_15]
                strap_done_d = 1'b1;
            end
        end

        if (stop_seen)
        begin
            state_d = qdi_pkg::DS_IDLE; // [RULE_07]
            oe_d    = 1'b0;
            hs_d    = 1'b0; // [RULE_09]
        end
        else if (start_seen)
        begin
            // A repeated start leaves the speed mode alone.
            state_d = qdi_pkg::DS_RX; // [RULE_03] [RULE_09]
            phase_d = qdi_pkg::PH_ADDR;
            bit_d   = 4'h0;
            oe_d    = 1'b0;
        end
        else
        begin
            case (state_q)
                qdi_pkg::DS_RX:
                begin
                    if (scl_rise && bit_q < 4'h8)
                    begin
                        // The master keeps SDA still while SCL is high, so the rising edge is a safe sample.
                        shift_d = {shift_q[6:0], sda_s2_q}; // [RULE_04]
                        bit_d   = bit_q + 4'h1;
                    end
                    else if (scl_fall && bit_q == 4'h8)
                    begin
                        state_d = qdi_pkg::DS_ACK; // [RULE_06]
                        oe_d    = 1'b1;
                        rd_d    = 1'b0;
                        case (phase_q)
                            qdi_pkg::PH_ADDR:
                            begin
                                if (own_addr(shift_q, strap_q[1:0]))
                                begin
                                    rd_d = shift_q[0]; // [RULE_05]
                                end
                                else if (shift_q == `QDI_BCAST_WRITE)
                                begin
                                    rd_d = 1'b0; // [RULE_16] [RULE_17]
                                end
                                else
                                begin
                                    // General call, ten-bit headers and foreign addresses all land here.
                                    state_d = qdi_pkg::DS_SKIP; // [RULE_02] [RULE_22]
                                    oe_d    = 1'b0;
                                    if (shift_q[7:3] == `QDI_MCODE_PREFIX)
                                    begin
                                        hs_d = 1'b1; // [RULE_08]
                                    end
                                end
                            end
                            qdi_pkg::PH_CTRL: ctl_d = shift_q; // [RULE_10]
                            qdi_pkg::PH_MSB:  msb_d = shift_q; // [RULE_10]
                            default:          lsb_d = shift_q; // [RULE_10]
                        endcase
                    end
                end
                qdi_pkg::DS_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_d    = 1'b0;
                        bit_d   = 4'h0;
                        state_d = rd_q ? qdi_pkg::DS_SKIP : qdi_pkg::DS_RX;
                        case (phase_q)
                            qdi_pkg::PH_ADDR: phase_d = qdi_pkg::PH_CTRL;
                            qdi_pkg::PH_CTRL: phase_d = qdi_pkg::PH_MSB;
                            qdi_pkg::PH_MSB:  phase_d = qdi_pkg::PH_LSB;
                            default:
                            begin
                                // Straight back to MSB so the next pair needs no control byte.
                                phase_d = qdi_pkg::PH_MSB; // [RULE_12] [RULE_13]
                                if (mode == qdi_pkg::LM_BCAST)
                                begin
                                    commit_d = 1'b1; // [RULE_11]
                                    for (int i = 0; i < N; i++)
                                    begin
                                        if (ctl_q[`QDI_CTL_SEL_HI])
                                        begin
                                            hold_d[i] = new_word; // [RULE_21]
                                            act_d[i]  = new_word;
                                        end
                                        else
                                        begin
                                            act_d[i] = hold_q[i]; // [RULE_21]
                                        end
                                    end
                                end
                                else if (ctl_q[`QDI_CTL_EXT] == strap_q[3:2]) // [RULE_19]
                                begin
                                    commit_d = (mode != qdi_pkg::LM_HOLD); // [RULE_11]
                                    for (int i = 0; i < N; i++)
                                    begin
                                        if (i[1:0] == sel)
                                        begin
                                            hold_d[i] = new_word; // [RULE_20]
                                            if (mode != qdi_pkg::LM_HOLD)
                                            begin
                                                act_d[i] = new_word;
                                            end
                                        end
                                        else if (mode == qdi_pkg::LM_SYNC)
                                        begin
                                            act_d[i] = hold_q[i]; // [RULE_20]
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            strap_q      <= 4'h0;
            settle_q     <= 2'h0;
            strap_done_q <= 1'b0;
            state_q      <= qdi_pkg::DS_IDLE;
            phase_q      <= qdi_pkg::PH_ADDR;
            bit_q        <= 4'h0;
            shift_q      <= 8'h00;
            oe_q         <= 1'b0;
            rd_q         <= 1'b0;
            hs_q         <= 1'b0;
            commit_q     <= 1'b0;
            ctl_q        <= `QDI_CTL_RESET;
            msb_q        <= 8'h00;
            lsb_q        <= 8'h00;
            for (int i = 0; i < N; i++)
            begin
                hold_q[i] <= '0;
                act_q[i]  <= '0;
            end
        end
        else
        begin
            strap_q      <= strap_d;
            settle_q     <= settle_d;
            strap_done_q <= strap_done_d;
            state_q      <= state_d;
            phase_q      <= phase_d;
            bit_q        <= bit_d;
            shift_q      <= shift_d;
            oe_q         <= oe_d;
            rd_q         <= rd_d;
            hs_q         <= hs_d;
            commit_q     <= commit_d;
            ctl_q        <= ctl_d;
            msb_q        <= msb_d;
            lsb_q        <= lsb_d;
            hold_q       <= hold_d;
            act_q        <= act_d;
        end
    end

    // ==========================================================
    // Outputs
    // The sampling runs on the core clock, so high-speed use needs SCL phases of four clocks or more.
    assign BUS.s_sda_o    = 1'b0;
    assign BUS.s_sda_oe   = oe_q; // [RULE_01] [RULE_05]
    assign O_COMMIT       = commit_q;
    assign O_HS_MODE      = hs_q;
    assign O_UPDATE_CONTROL = ctl_q;
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            O_DAC_WORD[i*W +: W] = act_q[i];
        end
    end

endmodule // qdi_dev

/* hw/qdi_host.sv */
`timescale 1ns/100ps
`include "qdi_consts.svh"

module qdi_host
(
    // Clock and reset
    input  wire logic          I_CLK,
    input  wire logic          I_RESET,
    // APB slave
    input  wire logic          I_PSEL,
    input  wire logic          I_PENABLE,
    input  wire logic          I_PWRITE,
    input  wire logic [7:0]    I_PADDR,
    input  wire logic [31:0]   I_PWDATA,
    output logic      [31:0]   O_PRDATA,
    output logic               O_PREADY,
    output logic               O_PSLVERR,
    // Two-wire bus
    qdi_bus_if.host            BUS
);

    // ==========================================================
    // Declarations
    qdi_pkg::qdi_hstate_t  state_q, state_d;
    logic [1:0]            step_q, step_d;
    logic [3:0]            bit_q, bit_d;
    logic [7:0]            byte_q, byte_d;
    logic [15:0]           timer_q, timer_d;
    logic [15:0]           div_q, div_d;
    logic                  scl_oe_q, scl_oe_d;
    logic                  sda_oe_q, sda_oe_d;
    logic                  ack_q, ack_d;
    logic                  pready_q, pready_d;
    logic [31:0]           prdata_q, prdata_d;
    logic                  sda_s1_q, sda_s2_q;
    logic                  busy;
    logic                  wr_take;

    assign busy    = (state_q != qdi_pkg::HS_IDLE) || (timer_q != 16'h0000);
    assign wr_take = I_PSEL && I_PENABLE && pready_q && I_PWRITE;

    // ==========================================================
    // Synchroniser for acknowledge sampling
    always_ff @(posedge I_CLK)
    begin
        sda_s1_q <= BUS.sda;
        sda_s2_q <= sda_s1_q;
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        state_d  = state_q;
        step_d   = step_q;
        bit_d    = bit_q;
        byte_d   = byte_q;
        timer_d  = timer_q;
        div_d    = div_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        ack_d    = ack_q;
        pready_d = 1'b0;
        prdata_d = prdata_q;

        // Answer one cycle after setup, so every transfer has exactly one access cycle.
        if (I_PSEL && !I_PENABLE)
        begin
            pready_d = 1'b1;
            case (I_PADDR)
                `QDI_REG_STATUS: prdata_d = {30'h0, ack_q, busy};
                `QDI_REG_DIV:    prdata_d = {16'h0, div_q};
                default:         prdata_d = 32'h0;
            endcase
        end
        if (wr_take && I_PADDR == `QDI_REG_DIV)
        begin
            div_d = I_PWDATA[15:0];
        end

        if (timer_q != 16'h0000)
        begin
            timer_d = timer_q - 16'h0001;
        end
        else
        begin
            case (state_q)
                qdi_pkg::HS_IDLE:
                begin
                    // Commands that arrive while busy are dropped; software polls the busy bit.
                    if (wr_take && I_PADDR == `QDI_REG_CMD && I_PWDATA[1:0] != 2'h0)
                    begin
                        step_d = 2'h0;
                        bit_d  = 4'h0;
                        byte_d = I_PWDATA[15:8];
                        case (I_PWDATA[1:0])
                            `QDI_OP_START: state_d = qdi_pkg::HS_START;
                            `QDI_OP_WRITE: state_d = qdi_pkg::HS_WRITE;
                            default:       state_d = qdi_pkg::HS_STOP;
                        endcase
                    end
                end
                qdi_pkg::HS_START:
                begin
                    timer_d = div_q;
                    step_d  = step_q + 2'h1;
                    case (step_q)
                        2'h0: sda_oe_d = 1'b0;
                        2'h1: scl_oe_d = 1'b0;
                        2'h2: sda_oe_d = 1'b1; // [RULE_03]
                        default:
                        begin
                            scl_oe_d = 1'b1;
                            state_d  = qdi_pkg::HS_IDLE;
                        end
                    endcase
                end
                qdi_pkg::HS_WRITE:
                begin
                    timer_d = div_q;
                    case (step_q)
                        2'h0:
                        begin
                            sda_oe_d = (bit_q < 4'h8) && !byte_q[3'h7 - bit_q[2:0]]; // [RULE_04]
                            step_d   = 2'h1;
                        end
                        2'h1:
                        begin
                            scl_oe_d = 1'b0;
                            step_d   = 2'h2;
                        end
                        default:
                        begin
                            if (bit_q == 4'h8)
                            begin
                                ack_d   = !sda_s2_q; // [RULE_06]
                                state_d = qdi_pkg::HS_IDLE;
                            end
                            scl_oe_d = 1'b1;
                            bit_d    = bit_q + 4'h1;
                            step_d   = 2'h0;
                        end
                    endcase
                end
                default:
                begin
                    timer_d = div_q;
                    step_d  = step_q + 2'h1;
                    case (step_q)
                        2'h0: sda_oe_d = 1'b1;
                        2'h1: scl_oe_d = 1'b0;
                        default:
                        begin
                            sda_oe_d = 1'b0; // [RULE_07]
                            state_d  = qdi_pkg::HS_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            state_q  <= qdi_pkg::HS_IDLE;
            step_q   <= 2'h0;
            bit_q    <= 4'h0;
            byte_q   <= 8'h00;
            timer_q  <= 16'h0000;
            div_q    <= 16'(`QDI_DIV_RESET);
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            ack_q    <= 1'b0;
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            state_q  <= state_d;
            step_q   <= step_d;
            bit_q    <= bit_d;
            byte_q   <= byte_d;
            timer_q  <= timer_d;
            div_q    <= div_d;
            scl_oe_q <= scl_oe_d;
            sda_oe_q <= sda_oe_d;
            ack_q    <= ack_d;
            pready_q <= pready_d;
            prdata_q <= prdata_d;
        end
    end

    // ==========================================================
    // Outputs
    assign O_PRDATA     = prdata_q;
    assign O_PREADY     = pready_q;
    assign O_PSLVERR    = 1'b0;
    assign BUS.scl_o    = 1'b0;
    assign BUS.scl_oe   = scl_oe_q;
    assign BUS.m_sda_o  = 1'b0;
    assign BUS.m_sda_oe = sda_oe_q;

endmodule // qdi_host

/* hw/qdi_pkg.sv */
package qdi_pkg;
    typedef enum logic [1:0] {DS_IDLE, DS_RX, DS_ACK, DS_SKIP} qdi_dstate_t;
    typedef enum logic [1:0] {PH_ADDR, PH_CTRL, PH_MSB, PH_LSB} qdi_phase_t;
    typedef enum logic [1:0] {LM_HOLD, LM_ONE, LM_SYNC, LM_BCAST} qdi_load_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_WRITE, HS_STOP} qdi_hstate_t;
endpackage
